//--- shared/hmm_bus_if.sv
`timescale 1ns/1ps
interface hmm_bus_if (
    input wire logic clk_i
);
    logic cs;
    logic we;
    logic [10:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rdy;

    modport dev (input cs, input we, input addr, input wdata, output rdata, output rdy);
    modport host (output cs, output we, output addr, output wdata, input rdata, input rdy);
endinterface

//--- shared/hmm_pkg.sv
package hmm_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int RAM_DEPTH = 2048;
    localparam int NPORT = 4;

    // common segment
    localparam logic [10:0] OFS_ID0 = 11'h000;
    localparam logic [10:0] OFS_ID1 = 11'h001;
    localparam logic [10:0] OFS_ID2 = 11'h002;
    localparam logic [10:0] OFS_REV = 11'h003;
    localparam logic [10:0] OFS_MASK_LVL = 11'h004;
    localparam logic [10:0] OFS_TEST_A = 11'h005;
    localparam logic [10:0] OFS_PC_LO = 11'h006;
    localparam logic [10:0] OFS_PC_HI = 11'h007;
    localparam logic [10:0] OFS_TEST_B = 11'h008;
    localparam logic [10:0] OFS_CTRL0 = 11'h010;
    localparam logic [10:0] OFS_CTRL1 = 11'h011;
    localparam logic [10:0] OFS_CTRL2 = 11'h012;
    localparam logic [10:0] OFS_CTRL3 = 11'h013;
    localparam logic [10:0] OFS_PROV = 11'h014;
    localparam logic [10:0] OFS_SRST = 11'h015;
    localparam logic [10:0] OFS_PIRQ_MSK = 11'h016;
    localparam logic [10:0] OFS_PSIDE_MSK = 11'h017;
    localparam logic [10:0] OFS_TFIFO_MSK = 11'h018;
    localparam logic [10:0] OFS_PFIFO_MSK = 11'h019;
    localparam logic [10:0] OFS_IRQ_IND = 11'h020;
    localparam logic [10:0] OFS_IRQ_SUM = 11'h021;
    localparam logic [10:0] OFS_AUX = 11'h0f1;
    localparam logic [10:0] OFS_B2 = 11'h0f5;
    localparam logic [10:0] OFS_CSUM = 11'h6bd;
    localparam logic [10:0] OFS_REL1 = 11'h6be;
    localparam logic [10:0] OFS_REL2 = 11'h6bf;

    // per-port error counters and their stride
    localparam logic [10:0] OFS_CNT_P1 = 11'h033;
    localparam logic [10:0] CNT_STRIDE = 11'h030;

    // processor data RAM window and the locations open during reprogramming
    localparam logic [10:0] RAM_BASE = 11'h100;
    localparam logic [10:0] RPG_OK0 = 11'h100;
    localparam logic [10:0] RPG_OK1 = 11'h102;
    localparam logic [10:0] RPG_OK2 = 11'h103;

    // field positions
    localparam int REPROG_BIT = 7;
    localparam int PC_HI_W = 3;
    localparam int SR_ALL = 7;
    localparam int SR_ASIDE = 6;
    localparam int SR_BSIDE = 5;
    localparam int SR_CORE = 4;
    localparam int SR_INIT = 0;

    // defined bits per register, test-bit masks, reset value
    localparam logic [7:0] MSK_FULL = 8'hff;
    localparam logic [7:0] MSK_PROV = 8'h1f;
    localparam logic [7:0] MSK_SRST = 8'hf1;
    localparam logic [7:0] MSK_PIRQ = 8'h01;
    localparam logic [7:0] MSK_SUM = 8'h7f;
    localparam logic [7:0] MSK_AUX = 8'h08;
    localparam logic [7:0] MSK_B2 = 8'h80;
    localparam logic [7:0] MSK_PC_HI_USR = 8'h87;
    localparam logic [7:0] MSK_NONE = 8'h00;
    localparam logic [7:0] RST_REG = 8'h00;

    function automatic logic [10:0] hmm_cnt_addr(input int n);
        return 11'(OFS_CNT_P1 + 11'(n) * CNT_STRIDE);
    endfunction

    function automatic logic [7:0] hmm_rsvd_mask(input logic [10:0] a);
        case (a)
            OFS_PROV: return MSK_PROV;
            OFS_SRST: return MSK_SRST;
            OFS_PIRQ_MSK: return MSK_PIRQ;
            OFS_IRQ_SUM: return MSK_SUM;
            OFS_AUX: return MSK_AUX;
            OFS_B2: return MSK_B2;
            default: return MSK_FULL;
        endcase
    endfunction

    // what the host may set to one: reserved and test bits are forced low
    function automatic logic [7:0] hmm_host_mask(input logic [10:0] a);
        case (a)
            OFS_TEST_A, OFS_TEST_B: return MSK_NONE;
            OFS_PC_HI: return MSK_PC_HI_USR;
            default: return hmm_rsvd_mask(a);
        endcase
    endfunction

    function automatic logic hmm_is_mapped(input logic [10:0] a);
        logic hit;
        hit = (a <= OFS_TEST_B) || (a >= OFS_CTRL0 && a <= OFS_PFIFO_MSK);
        hit = hit || a == OFS_IRQ_IND || a == OFS_IRQ_SUM || a == OFS_AUX || a == OFS_B2;
        hit = hit || a >= RAM_BASE;
        for (int n = 0; n < NPORT; n++) begin
            hit = hit || a == hmm_cnt_addr(n);
        end
        return hit;
    endfunction

    function automatic logic hmm_reprog_ok(input logic [10:0] a);
        return a == RPG_OK0 || a == RPG_OK1 || a == RPG_OK2;
    endfunction
endpackage

//--- sim/hmm_bus_chk.sv
`timescale 1ns/1ps
module hmm_bus_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host bus
    input wire logic cs,
    input wire logic we,
    input wire logic [10:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rdy
);
    import hmm_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_rdy_pulse;
        rdy |=> !rdy;
    endproperty
    property p_rdy_in_cycle;
        rdy |-> cs;
    endproperty
    property p_reg_lat;
        $rose(cs) && addr < RAM_BASE |=> rdy;
    endproperty
    property p_ram_wait;
        $rose(cs) && addr >= RAM_BASE |=> !rdy;
    endproperty
    property p_hold;
        cs && !rdy |=> cs && $stable(addr) && $stable(we) && $stable(wdata);
    endproperty
    property p_release;
        rdy |=> !cs;
    endproperty
    property p_wo_read;
        rdy && !we && addr == OFS_SRST |-> rdata == 8'h00;
    endproperty
    property p_rsvd_read;
        rdy && !we && addr == OFS_PROV |-> rdata[7:5] == 3'h0;
    endproperty
    property p_rsvd_write;
        cs && we && addr == OFS_PROV |-> wdata[7:5] == 3'h0;
    endproperty
    property p_test_write;
        cs && we && (addr == OFS_TEST_A || addr == OFS_TEST_B) |-> wdata == 8'h00;
    endproperty
    property p_mapped;
        cs |-> hmm_is_mapped(addr);
    endproperty

    a_rdy_pulse: assert property (p_rdy_pulse) else $error("rdy longer than one cycle");
    a_rdy_in_cycle: assert property (p_rdy_in_cycle) else $error("rdy without cs");
    a_reg_lat: assert property (p_reg_lat) else $error("register answer late");
    a_ram_wait: assert property (p_ram_wait) else $error("ram answer too early");
    a_hold: assert property (p_hold) else $error("request changed before rdy");
    a_release: assert property (p_release) else $error("cs kept after rdy");
    a_wo_read: assert property (p_wo_read) else $error("write-only byte read nonzero");
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read set");
    a_rsvd_write: assert property (p_rsvd_write) else $error("reserved bits written");
    a_test_write: assert property (p_test_write) else $error("test byte nonzero");
    a_mapped: assert property (p_mapped) else $error("unmapped address on bus");

    c_reg_read: cover property (rdy && !we && addr < RAM_BASE);
    c_ram_read: cover property (rdy && !we && addr >= RAM_BASE);
    c_write: cover property (rdy && we);
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import hmm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic soft_rst_o, a_rst_o, b_rst_o, core_rst_o;
    logic [3:0] rst_seen = 4'h0;
    logic req_i = 1'b0;
    logic we_i = 1'b0;
    logic [10:0] addr_i = 11'h000;
    logic [7:0] wdata_i = 8'h00;
    logic core_req_i = 1'b0;
    logic core_we_i = 1'b0;
    logic [10:0] core_addr_i = 11'h000;
    logic [7:0] core_wdata_i = 8'h00;
    logic [3:0] cnt_evt_i = 4'h0;
    logic [6:0] irq_src_i = 7'h05;
    logic busy_o, done_o, err_o, core_gnt_o, ram_init_busy_o;
    logic reprogram_o, aux_v4_en_o, tx_b2_dis_o;
    logic [7:0] rdata_o, core_rdata_o, prov_o, rd_v;
    logic [10:0] pc_load_o;
    logic [31:0] ctrl_o;
    logic er_v;
    int failures = 0;
    int compares = 0;
    int k;
    realtime t0;
    // identity values are arbitrary
    logic [7:0] idv [5] = '{8'h96, 8'h69, 8'h33, 8'h76, 8'h00};
    logic [10:0] rwa [12] = '{11'h010, 11'h011, 11'h012, 11'h013, 11'h014, 11'h0f1,
        11'h0f5, 11'h021, 11'h016, 11'h017, 11'h018, 11'h019};
    logic [7:0] rwd [12] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h1f, 8'h08,
        8'h80, 8'h7f, 8'h01, 8'ha5, 8'h5a, 8'hc3};

    always #50 clk_i = ~clk_i;

    // remembers the last set of reset pulses the command byte produced
    always @(posedge clk_i) begin
        if (soft_rst_o || a_rst_o || b_rst_o || core_rst_o) begin
            rst_seen <= {soft_rst_o, a_rst_o, b_rst_o, core_rst_o};
        end
    end

    hmm_bus_if hmm_bus_if_i (.clk_i(clk_i));

    hmm_dev_end #(.ID0(8'h96), .ID1(8'h69), .ID2(8'h33), .REV(4'h7), .REV_LO(4'h6))
    hmm_dev_end_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus(hmm_bus_if_i.dev),
        .core_req_i(core_req_i), .core_we_i(core_we_i), .core_addr_i(core_addr_i),
        .core_wdata_i(core_wdata_i), .core_gnt_o(core_gnt_o), .core_rdata_o(core_rdata_o),
        .cnt_evt_i(cnt_evt_i), .irq_src_i(irq_src_i), .pc_load_o(pc_load_o),
        .reprogram_o(reprogram_o), .ctrl_o(ctrl_o), .prov_o(prov_o),
        .aux_v4_en_o(aux_v4_en_o), .tx_b2_dis_o(tx_b2_dis_o), .soft_rst_o(soft_rst_o),
        .a_rst_o(a_rst_o), .b_rst_o(b_rst_o), .core_rst_o(core_rst_o),
        .ram_init_busy_o(ram_init_busy_o)
    );

    hmm_host_end hmm_host_end_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .we_i(we_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
        .err_o(err_o), .rdata_o(rdata_o), .bus(hmm_bus_if_i.host)
    );

    hmm_bus_chk hmm_bus_chk_i (
        .clk_i(clk_i), .rst_i(rst_i), .cs(hmm_bus_if_i.cs), .we(hmm_bus_if_i.we),
        .addr(hmm_bus_if_i.addr), .wdata(hmm_bus_if_i.wdata),
        .rdata(hmm_bus_if_i.rdata), .rdy(hmm_bus_if_i.rdy)
    );

    task automatic give_verdict();
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic miss(input string m);
        failures++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miss($sformatf("value %h expected %h", got, exp));
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miss($sformatf("flag %b expected %b", got, exp));
        end
    endtask

    // one user request, waits for done or refusal
    task automatic cyc(input logic w, input logic [10:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        #1;
        req_i = 1'b1;
        we_i = w;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i);
        #1;
        req_i = 1'b0;
        n = 0;
        while (!(done_o === 1'b1 || err_o === 1'b1) && n < 3000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 3000) begin
            miss("request timed out");
            give_verdict();
        end
        rd_v = rdata_o;
        er_v = err_o;
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        cyc(1'b1, a, d);
        chkb(er_v, 1'b0);
    endtask

    task automatic rd(input logic [10:0] a, input logic [7:0] exp);
        cyc(1'b0, a, 8'h00);
        chk(32'(rd_v), 32'(exp));
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        foreach (idv[i]) rd(11'(i), idv[i]);
        for (k = 0; k < 12; k++) begin
            wr(rwa[k], rwd[k]);
            rd(rwa[k], rwd[k]);
        end
        chkb(busy_o, 1'b0);
        chk(ctrl_o, 32'h7856_3412);
        chk(32'(prov_o), 32'h0000_001f);
        chkb(aux_v4_en_o, 1'b1);
        chkb(tx_b2_dis_o, 1'b1);
        rd(OFS_IRQ_IND, 8'h85);
        wr(OFS_IRQ_IND, 8'h00);
        rd(OFS_IRQ_IND, 8'h85);
        wr(OFS_PC_LO, 8'ha5);
        wr(OFS_PC_HI, 8'h7d);
        chk(32'(pc_load_o), 32'h0000_05a5);
        rd(OFS_PC_HI, 8'h05);
        wr(OFS_TEST_A, 8'hff);
        rd(OFS_TEST_A, 8'h00);
        cyc(1'b0, 11'h009, 8'h00);
        chkb(er_v, 1'b1);
        rd(OFS_SRST, 8'h00);
        wr(11'h200, 8'h5c);
        wr(OFS_PC_HI, 8'h80);
        chkb(reprogram_o, 1'b1);
        cyc(1'b1, 11'h200, 8'hff);
        chkb(er_v, 1'b1);
        wr(RPG_OK1, 8'h3c);
        rd(RPG_OK1, 8'h3c);
        wr(OFS_PC_HI, 8'h00);
        rd(11'h200, 8'h5c);
        // core holds the RAM port while the host waits
        @(posedge clk_i);
        #1;
        core_req_i = 1'b1;
        core_we_i = 1'b1;
        core_addr_i = 11'h300;
        core_wdata_i = 8'hc3;
        @(posedge clk_i);
        #1;
        core_we_i = 1'b0;
        t0 = $realtime;
        fork
            begin
                repeat (40) @(posedge clk_i);
                #1;
                chk(32'(core_rdata_o), 32'h0000_00c3);
                chkb(busy_o, 1'b1);
                core_req_i = 1'b0;
            end
            rd(11'h300, 8'hc3);
        join
        chkb(($realtime - t0) > 4000.0, 1'b1);
        for (k = 0; k < 4; k++) begin
            @(posedge clk_i);
            #1;
            cnt_evt_i[k] = 1'b1;
            repeat (k + 2) @(posedge clk_i);
            #1;
            cnt_evt_i[k] = 1'b0;
            rd(11'h033 + 11'(k) * 11'h030, 8'(k + 2));
            rd(11'h033 + 11'(k) * 11'h030, 8'h00);
        end
        // events while the clock enable is low must not count
        @(posedge clk_i);
        #1;
        ce_i = 1'b0;
        cnt_evt_i[1] = 1'b1;
        repeat (5) @(posedge clk_i);
        #1;
        ce_i = 1'b1;
        cnt_evt_i[1] = 1'b0;
        rd(11'h063, 8'h00);
        @(posedge clk_i);
        #1;
        cnt_evt_i[0] = 1'b1;
        repeat (300) @(posedge clk_i);
        #1;
        cnt_evt_i[0] = 1'b0;
        rd(OFS_CNT_P1, 8'hff);
        rd(OFS_CNT_P1, 8'h00);
        // hardware reset in mid-run: registers clear, RAM stays
        @(posedge clk_i);
        #1;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        chkb(tx_b2_dis_o, 1'b0);
        rd(11'h200, 8'h5c);
        wr(OFS_CTRL0, 8'h12);
        wr(OFS_SRST, 8'h80);
        chk(32'(rst_seen), 32'h0000_000f);
        rd(OFS_CTRL0, 8'h00);
        rd(11'h200, 8'h5c);
        wr(OFS_SRST, 8'h50);
        chk(32'(rst_seen), 32'h0000_0005);
        wr(OFS_SRST, 8'h01);
        chkb(ram_init_busy_o, 1'b1);
        chkb(core_gnt_o, 1'b0);
        rd(11'h200, 8'h00);
        rd(RPG_OK1, 8'h00);
        give_verdict();
    end
endmodule

//--- src/hmm_dev_end.sv
`timescale 1ns/1ps
// Notes on behaviour
// - byte map from 000H to 7FFH
// - host avoids unused or unlisted locations
// - reserved bits read as zero here
// - host writes reserved bits as zero
// - counters saturate, clear on host read
// - processor RAM survives resets, init clears
// - host stalled until RAM location free
// - reprogramming: host uses only 100H/102H/103H
// - host writes zero to test locations
// - common, side and per-port segments
// - access kinds honoured, write-only reads zero
module hmm_dev_end #(
    parameter int NP = hmm_pkg::NPORT,
    parameter int CNT_W = 8,
    // identity values below are arbitrary
    parameter logic [7:0] ID0 = 8'h5a,
    parameter logic [7:0] ID1 = 8'h3c,
    parameter logic [7:0] ID2 = 8'h0f,
    parameter logic [3:0] REV = 4'h3,
    parameter logic [3:0] REV_LO = 4'h2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // host bus
    hmm_bus_if.dev bus,
    // embedded core data RAM port
    input wire logic core_req_i,
    input wire logic core_we_i,
    input wire logic [hmm_pkg::ADDR_W-1:0] core_addr_i,
    input wire logic [7:0] core_wdata_i,
    output logic core_gnt_o,
    output logic [7:0] core_rdata_o,
    // events and status
    input wire logic [NP-1:0] cnt_evt_i,
    input wire logic [6:0] irq_src_i,
    // controls
    output logic [10:0] pc_load_o,
    output logic reprogram_o,
    output logic [31:0] ctrl_o,
    output logic [7:0] prov_o,
    output logic aux_v4_en_o,
    output logic tx_b2_dis_o,
    output logic soft_rst_o,
    output logic a_rst_o,
    output logic b_rst_o,
    output logic core_rst_o,
    output logic ram_init_busy_o
);
    import hmm_pkg::*;

    typedef enum logic [1:0] {DV_IDLE, DV_RAM, DV_HOLD} hmm_dst_t;

    hmm_dst_t dv_q;
    logic rdy_q, init_busy_q;
    logic [7:0] rdata_q, core_rdata_q, sr_q, wd, rd_val;
    logic [7:0] test_a_q, test_b_q, pc_lo_q, pc_hi_q;
    logic [7:0] prov_q, pirq_q, pside_q, tfifo_q, pfifo_q, sum_q, aux_q, b2_q;
    logic [3:0][7:0] ctrl_q;
    logic [7:0] ram_q [RAM_DEPTH];
    logic [10:0] init_q;
    logic [NP-1:0][CNT_W-1:0] cnt;
    logic [NP-1:0] cnt_clr;
    logic host_ram, reg_take, ram_take, host_take, host_wr, host_rd;
    logic [6:0] irq_masked;

    assign host_ram = bus.addr >= RAM_BASE;
    assign reg_take = ce_i && dv_q == DV_IDLE && bus.cs && !host_ram;
    // the core and the init sweep always win the RAM; the host waits
    assign ram_take = ce_i && dv_q == DV_RAM && bus.cs && !core_req_i && !init_busy_q;
    assign host_take = reg_take || ram_take;
    assign host_wr = host_take && bus.we;
    assign host_rd = host_take && !bus.we;
    assign wd = bus.wdata & hmm_rsvd_mask(bus.addr);
    assign irq_masked = irq_src_i & sum_q[6:0];

    assign bus.rdy = rdy_q;
    assign bus.rdata = rdata_q;
    assign core_gnt_o = !init_busy_q;
    assign core_rdata_o = core_rdata_q;
    assign pc_load_o = {pc_hi_q[PC_HI_W-1:0], pc_lo_q};
    assign reprogram_o = pc_hi_q[REPROG_BIT];
    assign ctrl_o = ctrl_q;
    assign prov_o = prov_q;
    assign aux_v4_en_o = aux_q[3];
    assign tx_b2_dis_o = b2_q[7];
    assign soft_rst_o = sr_q[SR_ALL];
    assign a_rst_o = sr_q[SR_ALL] || sr_q[SR_ASIDE];
    assign b_rst_o = sr_q[SR_ALL] || sr_q[SR_BSIDE];
    assign core_rst_o = sr_q[SR_ALL] || sr_q[SR_CORE];
    assign ram_init_busy_o = init_busy_q;

    // one error counter per port segment
    for (genvar n = 0; n < NP; n++) begin : g_cnt
        assign cnt_clr[n] = (host_rd && bus.addr == hmm_cnt_addr(n)) || sr_q[SR_ALL];
        hmm_sat_cnt #(.W(CNT_W)) u_cnt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .inc_i(cnt_evt_i[n]),
            .clr_i(cnt_clr[n]),
            .cnt_o(cnt[n])
        );
    end

    always_comb begin
        rd_val = RST_REG;
        case (bus.addr)
            OFS_ID0: rd_val = ID0;
            OFS_ID1: rd_val = ID1;
            OFS_ID2: rd_val = ID2;
            OFS_REV: rd_val = {REV, REV_LO};
            OFS_TEST_A: rd_val = test_a_q;
            OFS_PC_LO: rd_val = pc_lo_q;
            OFS_PC_HI: rd_val = pc_hi_q;
            OFS_TEST_B: rd_val = test_b_q;
            OFS_CTRL0: rd_val = ctrl_q[0];
            OFS_CTRL1: rd_val = ctrl_q[1];
            OFS_CTRL2: rd_val = ctrl_q[2];
            OFS_CTRL3: rd_val = ctrl_q[3];
            OFS_PROV: rd_val = prov_q;
            OFS_SRST: rd_val = RST_REG;
            OFS_PIRQ_MSK: rd_val = pirq_q;
            OFS_PSIDE_MSK: rd_val = pside_q;
            OFS_TFIFO_MSK: rd_val = tfifo_q;
            OFS_PFIFO_MSK: rd_val = pfifo_q;
            OFS_IRQ_IND: rd_val = {|irq_masked, irq_src_i};
            OFS_IRQ_SUM: rd_val = sum_q;
            OFS_AUX: rd_val = aux_q;
            OFS_B2: rd_val = b2_q;
            default: begin
                for (int n = 0; n < NP; n++) begin
                    if (bus.addr == hmm_cnt_addr(n)) begin
                        rd_val = 8'(cnt[n]);
                    end
                end
            end
        endcase
    end

    // host access sequencing
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dv_q <= DV_IDLE;
            rdy_q <= 1'b0;
            rdata_q <= RST_REG;
        end else if (ce_i) begin
            rdy_q <= host_take;
            if (host_rd) begin
                rdata_q <= host_ram ? ram_q[bus.addr] : rd_val;
            end
            case (dv_q)
                DV_IDLE: begin
                    if (bus.cs) begin
                        dv_q <= host_ram ? DV_RAM : DV_HOLD;
                    end
                end
                DV_RAM: begin
                    if (ram_take) begin
                        dv_q <= DV_HOLD;
                    end
                end
                DV_HOLD: begin
                    if (!bus.cs) begin
                        dv_q <= DV_IDLE;
                    end
                end
                default: dv_q <= DV_IDLE;
            endcase
        end
    end

    // writable common registers; a software reset clears them
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            test_a_q <= RST_REG;
            test_b_q <= RST_REG;
            pc_lo_q <= RST_REG;
            pc_hi_q <= RST_REG;
            ctrl_q <= '0;
            prov_q <= RST_REG;
            pirq_q <= RST_REG;
            pside_q <= RST_REG;
            tfifo_q <= RST_REG;
            pfifo_q <= RST_REG;
            sum_q <= RST_REG;
            aux_q <= RST_REG;
            b2_q <= RST_REG;
        end else if (ce_i) begin
            if (sr_q[SR_ALL]) begin
                test_a_q <= RST_REG;
                test_b_q <= RST_REG;
                pc_lo_q <= RST_REG;
                pc_hi_q <= RST_REG;
                ctrl_q <= '0;
                prov_q <= RST_REG;
                pirq_q <= RST_REG;
                pside_q <= RST_REG;
                tfifo_q <= RST_REG;
                pfifo_q <= RST_REG;
                sum_q <= RST_REG;
                aux_q <= RST_REG;
                b2_q <= RST_REG;
            end else if (host_wr && !host_ram) begin
                case (bus.addr)
                    OFS_TEST_A: test_a_q <= wd;
                    OFS_PC_LO: pc_lo_q <= wd;
                    OFS_PC_HI: pc_hi_q <= wd;
                    OFS_TEST_B: test_b_q <= wd;
                    OFS_CTRL0: ctrl_q[0] <= wd;
                    OFS_CTRL1: ctrl_q[1] <= wd;
                    OFS_CTRL2: ctrl_q[2] <= wd;
                    OFS_CTRL3: ctrl_q[3] <= wd;
                    OFS_PROV: prov_q <= wd;
                    OFS_PIRQ_MSK: pirq_q <= wd;
                    OFS_PSIDE_MSK: pside_q <= wd;
                    OFS_TFIFO_MSK: tfifo_q <= wd;
                    OFS_PFIFO_MSK: pfifo_q <= wd;
                    OFS_IRQ_SUM: sum_q <= wd;
                    OFS_AUX: aux_q <= wd;
                    OFS_B2: b2_q <= wd;
                    default: ;
                endcase
            end
        end
    end

    // reset command byte gives one-cycle pulses
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sr_q <= RST_REG;
        end else if (ce_i) begin
            sr_q <= (host_wr && bus.addr == OFS_SRST) ? wd : RST_REG;
        end
    end

    // RAM init sweep over every location
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_q <= '0;
            init_busy_q <= 1'b0;
        end else if (ce_i) begin
            if (sr_q[SR_INIT]) begin
                init_q <= '0;
                init_busy_q <= 1'b1;
            end else if (init_busy_q) begin
                init_q <= init_q + 11'h001;
                if (init_q == 11'(RAM_DEPTH - 1)) begin
                    init_busy_q <= 1'b0;
                end
            end
        end
    end

    // the array has no reset: only the init sweep clears it
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (init_busy_q) begin
                ram_q[init_q] <= RST_REG;
            end else if (core_req_i && core_we_i) begin
                ram_q[core_addr_i] <= core_wdata_i;
            end else if (ram_take && bus.we) begin
                ram_q[bus.addr] <= bus.wdata;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_rdata_q <= RST_REG;
        end else if (ce_i && core_req_i && !core_we_i && !init_busy_q) begin
            core_rdata_q <= ram_q[core_addr_i];
        end
    end
endmodule

//--- src/hmm_host_end.sv
`timescale 1ns/1ps
module hmm_host_end (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // user request
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [hmm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    // user answer
    output logic busy_o,
    output logic done_o,
    output logic err_o,
    output logic [7:0] rdata_o,
    // device bus
    hmm_bus_if.host bus
);
    import hmm_pkg::*;

    typedef enum logic {HS_IDLE, HS_WAIT} hmm_hst_t;

    hmm_hst_t hs_q;
    logic cs_q;
    logic we_q;
    logic [10:0] addr_q;
    logic [7:0] wdata_q;
    logic done_q;
    logic err_q;
    logic [7:0] rdata_q;
    logic reprog_q;
    logic legal;

    assign legal = hmm_is_mapped(addr_i)
        && !(reprog_q && addr_i >= RAM_BASE && !hmm_reprog_ok(addr_i));
    assign bus.cs = cs_q;
    assign bus.we = we_q;
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign busy_o = hs_q != HS_IDLE;
    assign done_o = done_q;
    assign err_o = err_q;
    assign rdata_o = rdata_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hs_q <= HS_IDLE;
            cs_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= RST_REG;
            done_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= RST_REG;
        end else if (ce_i) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            case (hs_q)
                HS_IDLE: begin
                    if (req_i && !legal) begin
                        err_q <= 1'b1;
                    end else if (req_i) begin
                        cs_q <= 1'b1;
                        we_q <= we_i;
                        addr_q <= addr_i;
                        wdata_q <= wdata_i & hmm_host_mask(addr_i);
                        hs_q <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    // hold the access until the device says it is done
                    if (bus.rdy) begin
                        cs_q <= 1'b0;
                        done_q <= 1'b1;
                        if (!we_q) begin
                            rdata_q <= bus.rdata;
                        end
                        hs_q <= HS_IDLE;
                    end
                end
                default: hs_q <= HS_IDLE;
            endcase
        end
    end

    // shadow of the reprogram bit, tracked from our own writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reprog_q <= 1'b0;
        end else if (ce_i && hs_q == HS_IDLE && req_i && legal && we_i) begin
            if (addr_i == OFS_PC_HI) begin
                reprog_q <= wdata_i[REPROG_BIT];
            end else if (addr_i == OFS_SRST && wdata_i[SR_ALL]) begin
                reprog_q <= 1'b0;
            end
        end
    end
endmodule

//--- src/hmm_sat_cnt.sv
`timescale 1ns/1ps
module hmm_sat_cnt #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // control
    input wire logic inc_i,
    input wire logic clr_i,
    // count
    output logic [W-1:0] cnt_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_o <= '0;
        end else if (ce_i) begin
            if (clr_i) begin
                // an event in the clearing cycle is kept
                cnt_o <= inc_i ? W'(1) : '0;
            end else if (inc_i && cnt_o != {W{1'b1}}) begin
                cnt_o <= cnt_o + W'(1);
            end
        end
    end
endmodule
